// *** verification/swr_reader_props.sv ***
/* Port checker for swr_reader, bound after the module.
   Assumes only the reader's own ports. */
`timescale 1ns/100ps
module swr_reader_props #(
  parameter LEN_W = 8
) (
  input wire             clk,
  input wire             nrst,
  input wire             start,
  input wire [2:0]       mode,
  input wire             busy,
  input wire [7:0]       dataOut,
  input wire             dataValid,
  input wire [LEN_W-1:0] dataIndex,
  input wire             done,
  input wire             noPresence,
  input wire             dqOut,
  input wire             dqOe
);
  reg bitMode_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Mode is only taken when idle, so track it the same way
  always @(posedge clk or negedge nrst)
    if (!nrst) bitMode_reg <= 1'b0;
    else if (start && !busy) bitMode_reg <= mode[2];
  a_pin_low_only: assert property (dqOut == 1'b0) else $error("pin driven high");
  a_done_releases: assert property (done |-> !dqOe) else $error("pin held at end");
  a_done_ends_busy: assert property (done |-> !busy) else $error("busy after done");
  a_valid_single: assert property (dataValid |=> !dataValid) else $error("valid too long");
  a_index_steps: assert property (dataValid |=> dataIndex == $past(dataIndex) + 1'b1) else $error("index stuck");
  a_bit_one_bit: assert property (dataValid && bitMode_reg |-> dataOut[7:1] == 7'h00) else $error("wide bit");
  a_start_taken: assert property (start && !busy |-> ##[1:2] busy) else $error("start lost");
  a_no_data_flag: assert property (noPresence |-> !dataValid) else $error("data after absence");
  a_flag_abandons: assert property ($rose(noPresence) |-> ##[0:2] !busy) else $error("not abandoned");
  c_bit_data: cover property (dataValid && bitMode_reg);
  c_no_presence: cover property ($rose(noPresence));
  c_clean_end: cover property (done && !noPresence);
endmodule
bind swr_reader swr_reader_props #(.LEN_W(LEN_W)) chk (.clk(clk), .nrst(nrst), .start(start), .mode(mode),
  .busy(busy), .dataOut(dataOut), .dataValid(dataValid), .dataIndex(dataIndex), .done(done),
  .noPresence(noPresence), .dqOut(dqOut), .dqOe(dqOe));

// *** verification/swr_reader_tb_top.sv ***
/* Bench for swr_reader with a behavioural slave.
   Assumes shortened reset timing and a shortened read slot (SLOT_CYC, REC_CYC); slot low and sample times are default. */
`timescale 1ns/100ps
module swr_reader_tb_top;
  reg         clk = 1'b0, nrst = 1'b0, start = 1'b0, present = 1'b1, rew = 1'b0;
  reg  [2:0]  mode = 3'h0;
  reg  [7:0]  count = 8'h00;
  reg  [15:0] bits = 16'h0000;
  wire        busy, dataValid, done, noPresence, dqOut, dqOe, slvLow;
  wire [7:0]  dataOut, dataIndex;
  wire        line = ~(dqOe | slvLow);
  integer     err_total = 0, n_tests = 0, nGot = 0, runLen = 0, longCnt = 0, preLong = 0, k;
  swr_reader #(.RST_LOW_CYC(40), .PRES_CYC(20), .RST_TOT_CYC(80), .SLOT_CYC(150),
    .REC_CYC(2)) uut (.clk(clk), .nrst(nrst), .start(start), .mode(mode), .count(count), .busy(busy),
    .dataOut(dataOut), .dataValid(dataValid), .dataIndex(dataIndex), .done(done), .noPresence(noPresence),
    .dqIn(line), .dqOut(dqOut), .dqOe(dqOe));
  swr_slave_model slave (.clk(clk), .mstLow(dqOe), .present(present), .rew(rew), .bits(bits), .pullLow(slvLow));
  initial forever #50 clk = ~clk;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (err_total == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    runLen <= dqOe ? runLen + 1 : 0;
    if (!dqOe && runLen >= 40) begin
      longCnt <= longCnt + 1;
      if (nGot == 0) preLong <= 1;
    end
    if (dataValid) begin
      check(dataOut, mode[2] ? {7'h00, bits[nGot % 16]} : bits[8*(nGot % 2) +: 8]);
      check(dataIndex, nGot);
      nGot <= nGot + 1;
    end
  end
  task run(input [2:0] m, input [7:0] c, input [15:0] d, input p);
    integer i;
    begin
      mode = m;
      count = c;
      bits = d;
      present = p;
      rew = 1'b1;
      nGot = 0;
      longCnt = 0;
      preLong = 0;
      @(negedge clk);
      rew = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (3) @(negedge clk);
      start = 1'b1; // A start while busy must be ignored
      @(negedge clk);
      start = 1'b0;
      for (i = 0; i < 45000 && done !== 1'b1; i = i + 1) @(negedge clk);
      @(negedge clk);
      check(i < 45000, 1'b1);
      check(nGot, (m[0] && !p) ? 0 : ((c == 8'h00) ? 255 : c));
      check(noPresence, !p && m[1:0] != 2'b00);
      check(longCnt, m[0] + (m[1] && (p || !m[0])));
      check(preLong, m[0]);
      check({busy, dqOe}, 2'b00);
    end
  endtask
  task byte_modes;
    begin
      run(3'h0, 8'h02, 16'hA53C, 1'b1);
      run(3'h1, 8'h02, 16'h0FF1, 1'b1);
    end
  endtask
  task bit_modes;
    for (k = 4; k < 8; k = k + 1) run(k[2:0], 8'h03, 16'h0005, 1'b1);
  endtask
  task trailing_resets;
    begin
      run(3'h2, 8'h01, 16'h0080, 1'b1);
      run(3'h3, 8'h01, 16'h00FF, 1'b1);
    end
  endtask
  task lost_presence;
    begin
      run(3'h1, 8'h02, 16'h1234, 1'b0);
      run(3'h6, 8'h02, 16'h0002, 1'b0);
      run(3'h4, 8'h01, 16'h0001, 1'b1);
    end
  endtask
  task fill_all;
    run(3'h4, 8'h00, 16'h6C39, 1'b1);
  endtask
  initial begin
    #(100 * 70000);
    err_total = err_total + 1;
    stop_test;
  end
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    byte_modes;
    bit_modes;
    trailing_resets;
    lost_presence;
    fill_all;
    stop_test;
  end
endmodule

// *** verification/swr_slave_model.sv ***
/* Behavioural slave: presence and read-slot replies.
   Assumes it sees the master's drive and shares the system clock. */
`timescale 1ns/100ps
module swr_slave_model (
  input wire        clk,
  input wire        mstLow,
  input wire        present,
  input wire        rew,
  input wire [15:0] bits,
  output reg        pullLow
);
  integer   lowCnt = 0, hold = 0, dly = 0;
  reg [3:0] idx = 4'h0;
  reg       mstLowD = 1'b0;
  initial pullLow = 1'b0;
  always @(posedge clk) begin
    mstLowD <= mstLow;
    lowCnt <= mstLow ? lowCnt + 1 : 0;
    if (dly > 0) dly <= dly - 1;
    if (hold > 0) hold <= hold - 1;
    if (hold == 1) pullLow <= 1'b0;
    if (mstLow && lowCnt == 30) begin // A long low is a reset: drop any slot answer
      pullLow <= 1'b0;
      hold <= 0;
    end
    if (mstLow && !mstLowD && !bits[idx]) begin // Zero holds past the sample point
      pullLow <= 1'b1;
      hold <= 130;
    end
    if (!mstLow && mstLowD) begin
      idx <= (lowCnt >= 30) ? 4'h0 : idx + 4'h1; // Long low is a bus reset
      if (lowCnt >= 30 && present) dly <= 3;
    end
    if (dly == 1) begin
      pullLow <= 1'b1; // Presence answer
      hold <= 30;
    end
    if (rew) idx <= 4'h0;
  end
endmodule

// *** verilog/swr_reader.v ***
/*
  Single-wire bus master read engine: reset/presence handshake, read slots,
  byte or bit assembly into consecutive destination elements.
  Assumes an external pull-up; the pin is open drain (drive low or release).
  Commands are issued beforehand by a separate write engine.
*/
`timescale 1ns/100ps
`include "swr_regs.vh"
module swr_reader #(
  parameter CNT_W       = 16,
  parameter RST_LOW_CYC = `SWR_RST_LOW_US * `SWR_CLK_MHZ,
  parameter PRES_CYC    = `SWR_PRES_SMP_US * `SWR_CLK_MHZ,
  parameter RST_TOT_CYC = `SWR_RST_TOTAL_US * `SWR_CLK_MHZ,
  parameter SLOT_CYC    = `SWR_SLOT_US * `SWR_CLK_MHZ,
  parameter LOW_CYC     = `SWR_SLOT_LOW_US * `SWR_CLK_MHZ,
  parameter SMP_CYC     = `SWR_SAMPLE_US * `SWR_CLK_MHZ,
  parameter REC_CYC     = `SWR_RECOVER_US * `SWR_CLK_MHZ,
  parameter LEN_W       = 8
) (
  clk,
  nrst,
  start,
  mode,
  count,
  busy,
  dataOut,
  dataValid,
  dataIndex,
  done,
  noPresence,
  dqIn,
  dqOut,
  dqOe
);
  input  wire             clk;
  input  wire             nrst;
  input  wire             start;
  input  wire [2:0]       mode;
  input  wire [LEN_W-1:0] count;
  output reg              busy;
  output reg  [7:0]       dataOut;
  output reg              dataValid;
  output reg  [LEN_W-1:0] dataIndex;
  output reg              done;
  output reg              noPresence;
  input  wire             dqIn;
  output reg              dqOut;
  output reg              dqOe;

  localparam S_IDLE  = 3'd0;
  localparam S_RLOW  = 3'd1;
  localparam S_RPRES = 3'd2;
  localparam S_RTAIL = 3'd3;
  localparam S_SLOW  = 3'd4;
  localparam S_SWAIT = 3'd5;
  localparam S_SREC  = 3'd6;

  reg [2:0]       state_reg;
  reg [2:0]       mode_reg;
  reg [LEN_W-1:0] left_reg;
  reg [2:0]       bit_reg;
  reg [7:0]       shift_reg;
  reg             after_reg;
  reg             presSeen_reg;
  reg             tLoad;
  reg [CNT_W-1:0] tCount;
  wire [CNT_W-1:0] tCnt;
  wire            tDone;

  // Timer takes its count one cycle after tLoad; done clears on load,
  // so a state entered with a fresh load never sees a stale expiry.
  swr_slot_timer #(.W(CNT_W)) u_timer (
    .clk   (clk),
    .nrst  (nrst),
    .load  (tLoad),
    .count (tCount),
    .cnt   (tCnt),
    .done  (tDone)
  );

  function [CNT_W-1:0] cyc;
    input integer n;
    begin
      cyc = n[CNT_W-1:0];
    end
  endfunction

  // Open drain: dqOut stays low and dqOe alone pulls the line;
  // driving high would fight the pull-up and the slaves.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= S_IDLE;
      mode_reg     <= 3'd0;
      left_reg     <= {LEN_W{1'b0}};
      bit_reg      <= 3'd0;
      shift_reg    <= 8'h00;
      after_reg    <= 1'b0;
      presSeen_reg <= 1'b0;
      tLoad        <= 1'b0;
      tCount       <= {CNT_W{1'b0}};
      busy         <= 1'b0;
      dataOut      <= 8'h00;
      dataValid    <= 1'b0;
      dataIndex    <= {LEN_W{1'b0}};
      done         <= 1'b0;
      noPresence   <= 1'b0;
      dqOut        <= 1'b0;
      dqOe         <= 1'b0;
    end else begin
      tLoad     <= 1'b0;
      dataValid <= 1'b0;
      done      <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          dqOe <= 1'b0; // Released between operations
          if (start) begin
            mode_reg   <= mode;
            left_reg   <= (count == {LEN_W{1'b0}}) ? {LEN_W{1'b1}} : count; // Zero means fill all
            dataIndex  <= {LEN_W{1'b0}};
            noPresence <= 1'b0;
            busy       <= 1'b1;
            after_reg  <= 1'b0;
            bit_reg    <= 3'd0;
            tLoad      <= 1'b1;
            // Initialisation first when asked for; otherwise a slot starts at once
            if (mode[`SWR_MODE_RST_BEFORE]) begin
              state_reg <= S_RLOW;
              tCount    <= cyc(RST_LOW_CYC);
              dqOe      <= 1'b1; // Reset pulse
            end else begin
              state_reg <= S_SLOW;
              tCount    <= cyc(LOW_CYC);
              dqOe      <= 1'b1;
            end
          end
        end
        S_RLOW: if (tDone) begin
          dqOe         <= 1'b0;
          presSeen_reg <= 1'b0;
          tLoad        <= 1'b1;
          tCount       <= cyc(PRES_CYC - RST_LOW_CYC + RST_TOT_CYC - PRES_CYC);
          state_reg    <= S_RPRES;
        end
        S_RPRES: begin
          // Presence sampled once, at the sample point after release
          // Count runs down from the release; the load cycle is skipped
          if (!tLoad && tCnt == cyc(RST_TOT_CYC - RST_LOW_CYC - PRES_CYC)) begin
            presSeen_reg <= ~dqIn;
            state_reg    <= S_RTAIL;
          end
        end
        S_RTAIL: if (tDone) begin
          if (!presSeen_reg) begin
            noPresence <= 1'b1; // Abandon with no further data
            busy       <= 1'b0;
            done       <= 1'b1;
            state_reg  <= S_IDLE;
          end else if (after_reg) begin
            busy      <= 1'b0;
            done      <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            tLoad     <= 1'b1;
            tCount    <= cyc(LOW_CYC);
            dqOe      <= 1'b1;
            state_reg <= S_SLOW;
          end
        end
        S_SLOW: if (tDone) begin
          dqOe      <= 1'b0; // Brief low, then release
          tLoad     <= 1'b1;
          tCount    <= cyc(SMP_CYC - LOW_CYC);
          state_reg <= S_SWAIT;
        end
        S_SWAIT: if (tDone) begin
          // Sample point sits inside the read window; a late one reads the pull-up
          tLoad     <= 1'b1;
          tCount    <= cyc(SLOT_CYC - SMP_CYC + REC_CYC);
          state_reg <= S_SREC;
          if (mode_reg[`SWR_MODE_BIT]) begin
            dataOut   <= {7'h00, dqIn}; // One bit per element
            dataValid <= 1'b1;
          end else begin
            shift_reg <= {dqIn, shift_reg[7:1]}; // LSB first, as commands travel
            bit_reg   <= bit_reg + 3'd1;
            // Last bit completes the byte straight from the pin
            if (bit_reg == 3'd7) begin
              dataOut   <= {dqIn, shift_reg[7:1]};
              dataValid <= 1'b1;
            end
          end
        end
        S_SREC: begin
          // Index moves after the pulse, so it names the element while data stands
          if (dataValid) begin
            dataIndex <= dataIndex + {{(LEN_W-1){1'b0}}, 1'b1}; // Consecutive elements
            left_reg  <= left_reg - {{(LEN_W-1){1'b0}}, 1'b1};
          end
          if (tDone) begin
            tLoad <= 1'b1;
            if (left_reg != {LEN_W{1'b0}}) begin
              tCount    <= cyc(LOW_CYC);
              dqOe      <= 1'b1;
              state_reg <= S_SLOW;
            // Trailing reset reuses the reset states; after_reg ends it there
            end else if (mode_reg[`SWR_MODE_RST_AFTER]) begin
              after_reg <= 1'b1;
              tCount    <= cyc(RST_LOW_CYC);
              dqOe      <= 1'b1;
              state_reg <= S_RLOW;
            end else begin
              busy      <= 1'b0;
              done      <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
          dqOe      <= 1'b0;
        end
      endcase
    end
  end
endmodule

// *** verilog/swr_regs.vh ***
/*
  Constants for the single-wire bus read engine: modes, timing and command codes.
  Assumes a 10 MHz system clock; counts are derived from microsecond figures.
*/
`ifndef SWR_REGS_VH
`define SWR_REGS_VH
`define SWR_CLK_MHZ        10
`define SWR_RST_LOW_US     480
`define SWR_PRES_SMP_US    70
`define SWR_RST_TOTAL_US   960
`define SWR_SLOT_US        60
`define SWR_SLOT_LOW_US    2
`define SWR_SAMPLE_US      12
`define SWR_RECOVER_US     2
`define SWR_MODE_BIT       2
`define SWR_MODE_RST_BEFORE 0
`define SWR_MODE_RST_AFTER 1
`define SWR_CMD_READ_ID    8'h33
`define SWR_CMD_MATCH_ID   8'h55
`define SWR_CMD_SKIP_ID    8'hCC
`define SWR_CMD_SEARCH_ID  8'hF0
`endif

// *** verilog/swr_slot_timer.v ***
/*
  Cycle timer: loads a count and pulses done when it expires.
  Assumes one clock; load has priority over counting.
*/
`timescale 1ns/100ps
module swr_slot_timer #(
  parameter W = 16
) (
  clk,
  nrst,
  load,
  count,
  cnt,
  done
);
  input  wire         clk;
  input  wire         nrst;
  input  wire         load;
  input  wire [W-1:0] count;
  output wire [W-1:0] cnt;
  output reg          done;

  reg [W-1:0] cnt_reg;
  assign cnt = cnt_reg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= {W{1'b0}};
      done    <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      done    <= 1'b0;
    end else if (cnt_reg != {W{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      done    <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
    end else begin
      done <= 1'b0;
    end
  end
endmodule
